// ---- bench/ahc_host_model.sv ----
/*
  Host processor model for the register block: drives the control-write
  and register-read strobes, the byte chooser and the 16-bit write lines.
  Assumes one clock shared with the block and one calling process.
*/
`timescale 1ns/1ps
module ahc_host_model (
  input wire logic clk_i,
  input wire logic [15:0] rd_data_i,
  output logic cw_n_o,
  output logic rd_n_o,
  output logic sel_o,
  output logic [15:0] wr_data_o
);
  // ==========================================================
  // Idle levels: strobes high
  initial begin
    cw_n_o = 1'b1;
    rd_n_o = 1'b1;
    sel_o = 1'b0;
    wr_data_o = 16'h0000;
  end
  // Byte chooser, changed just after an edge
  task automatic pick(input logic s);
    @(posedge clk_i);
    sel_o <= s;
  endtask
  // Control write: all lines held through the low strobe, one high sample after
  task automatic wr(input logic [15:0] v);
    @(posedge clk_i);
    cw_n_o <= 1'b0;
    wr_data_o <= v;
    @(posedge clk_i);
    cw_n_o <= 1'b1;
    wr_data_o <= ~v; // Released lines no longer show the value
    @(posedge clk_i);
  endtask
  // Register read: chooser settled a cycle ahead, data sampled two cycles in
  task automatic rd(input logic s, output logic [15:0] v);
    pick(s);
    @(posedge clk_i);
    rd_n_o <= 1'b0;
    @(posedge clk_i);
    @(posedge clk_i);
    #1 v = rd_data_i;
    @(posedge clk_i);
    rd_n_o <= 1'b1;
  endtask
endmodule

// ---- bench/ahc_regs_bench.sv ----
/*
  Self-checking bench for the host configuration and status registers.
  Assumes the host model drives the host strobes; FIFO levels and load/read strobes come from here.
*/
`timescale 1ns/1ps
module ahc_regs_bench;
  logic clk, rst, mr_n, cw_n, rd_n, sel, oe, pl1_n, pl2_n, en1_n, en2_n, b32, h1, h2, a1, a2, lb, tll, r1l, r2l;
  logic [15:0] wd, rdat, half, v;
  logic [31:0] rxw, txw, w1, w2;
  logic [6:0] d1, d2, dt;
  logic [8:0] st;
  logic [7:0] pn;
  ahc_pkg::ahc_levels_t lv;
  int n_errors = 0;
  int checks = 0;
  ahc_host_model i_ahc_host_model (.clk_i(clk), .rd_data_i(rdat), .cw_n_o(cw_n), .rd_n_o(rd_n), .sel_o(sel),
    .wr_data_o(wd));
  ahc_regs i_ahc_regs (.ref_clk_i(clk), .reset_i(rst), .master_reset_n_i(mr_n), .control_write_strobe_n_i(cw_n),
    .register_read_strobe_n_i(rd_n), .byte_choose_i(sel), .host_bus_i(wd), .host_bus_o(rdat), .host_bus_oe_o(oe),
    .levels_i(lv), .tx_load_low_half_n_i(pl1_n), .tx_load_high_half_n_i(pl2_n), .rx1_read_n_i(en1_n),
    .rx2_read_n_i(en2_n), .rx_word_i(rxw), .rx_label_i(8'h00), .rx_half_o(half), .tx_word_i(txw),
    .tx_bit32_o(b32), .rx1_word_i(w1), .rx1_label_hit_i(h1), .rx1_accept_o(a1), .rx2_word_i(w2),
    .rx2_label_hit_i(h2), .rx2_accept_o(a2), .rx1_divide_o(d1), .rx2_divide_o(d2), .tx_divide_o(dt),
    .loopback_o(lb), .tx_label_load_o(tll), .rx1_label_read_o(r1l), .rx2_label_read_o(r2l), .fifo_status_o(st),
    .rx1_has_data_n_o(pn[0]), .rx1_half_level_n_o(pn[1]), .rx1_queue_full_n_o(pn[2]), .rx2_has_data_n_o(pn[3]),
    .rx2_half_level_n_o(pn[4]), .rx2_queue_full_n_o(pn[5]), .tx_queue_full_n_o(pn[6]), .tx_half_level_n_o(pn[7]));
  // ==========================================================
  // Clock, comparison and closing helpers
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // Control word write, readback, rates, loopback, master reset
  task automatic t_ctrl();
    logic [15:0] vals [3] = '{16'hffff, 16'ha5c3, 16'h0000};
    foreach (vals[i]) begin
      i_ahc_host_model.wr(vals[i]);
      i_ahc_host_model.rd(1'b1, v);
      chk("ctrl", v, vals[i]);
      chk("rx1 div", d1, vals[i][0] ? 7'h50 : 7'h0a);
      chk("rx2 div", d2, vals[i][14] ? 7'h50 : 7'h0a);
      chk("tx div", dt, vals[i][13] ? 7'h50 : 7'h0a);
      chk("loop", lb, !vals[i][5]);
    end
    i_ahc_host_model.wr(16'hffff);
    @(posedge clk);
    mr_n <= 1'b0;
    @(posedge clk);
    mr_n <= 1'b1;
    i_ahc_host_model.rd(1'b1, v);
    chk("ctrl rst", v, 16'h0000);
    chk("loop rst", lb, 1'b1);
    fork
      i_ahc_host_model.rd(1'b0, v);
      begin
        repeat (3) @(posedge clk);
        #2;
        chk("oe rd", oe, 1'b1);
      end
    join
    chk("status rst", v, 16'h0040);
    tick();
    chk("oe idle", oe, 1'b0);
    chk("bus idle", rdat, 16'h0000);
    $display("test ctrl done");
  endtask
  // ==========================================================
  // Status bits, pins and status read at level boundaries
  task automatic t_stat();
    logic [17:0] tb [5] = '{{6'h00, 6'h00, 6'h00}, {6'h01, 6'h0f, 6'h01}, {6'h10, 6'h1f, 6'h10},
      {6'h20, 6'h20, 6'h20}, {6'h0f, 6'h10, 6'h1f}};
    logic [8:0] s;
    foreach (tb[i]) begin
      @(posedge clk);
      lv <= tb[i];
      tick();
      s = {lv.tx >= 6'h10, lv.tx == 6'h20, lv.tx == 6'h00, lv.rx2 == 6'h20, lv.rx2 >= 6'h10, lv.rx2 != 6'h00,
        lv.rx1 == 6'h20, lv.rx1 >= 6'h10, lv.rx1 != 6'h00};
      chk("status", st, s);
      chk("pins", pn, 8'(~{s[8:7], s[5:0]}));
      i_ahc_host_model.rd(1'b0, v);
      chk("status rd", v, {7'h00, s});
    end
    $display("test status done");
  endtask
  // ==========================================================
  // Transmit bit 32: data, odd and even parity
  task automatic t_par();
    for (int i = 0; i < 8; i++) begin
      i_ahc_host_model.wr({3'h0, i[1], 7'h00, i[0], 4'h0});
      @(posedge clk);
      txw <= i[2] ? 32'h8000_0007 : 32'h0123_4566;
      tick();
      chk("bit32", b32, i[0] ? (i[1] ? ^txw[30:0] : ~^txw[30:0]) : txw[31]);
    end
    $display("test parity done");
  endtask
  // ==========================================================
  // Half-word mapping for both formats and both choosers
  task automatic t_fmt();
    logic [31:0] w;
    w = 32'h8e5a_3c71;
    rxw <= w;
    for (int i = 0; i < 4; i++) begin
      i_ahc_host_model.wr({i[1], 15'h0000});
      i_ahc_host_model.pick(i[0]);
      tick();
      case (i)
        0: chk("half", half, {w[12:8], w[30:29], w[31], w[7:0]});
        1: chk("half", half, w[28:13]);
        2: chk("half", half, w[15:0]);
        default: chk("half", half, w[31:16]);
      endcase
    end
    $display("test format done");
  endtask
  // ==========================================================
  // Decoder and label filter for both receivers
  task automatic t_dec();
    for (int i = 0; i < 16; i++) begin
      i_ahc_host_model.wr({4'h8, 1'b1, 1'b0, i[1], 1'b0, 1'b1, i[1], 1'b1, 1'b0, {2{i[0]}}, 2'h0});
      @(posedge clk);
      h1 <= i[2];
      h2 <= i[2];
      w1 <= {22'h0, i[3] ? 2'b01 : 2'b10, 8'h5c};
      w2 <= {22'h0, i[3] ? 2'b10 : 2'b01, 8'h5c};
      tick();
      chk("acc1", a1, (!i[0] || i[2]) && (!i[1] || i[3]));
      chk("acc2", a2, (!i[0] || i[2]) && (!i[1] || i[3]));
    end
    $display("test decoder done");
  endtask
  // ==========================================================
  // Label memory mode: 16 loads, then 16 receiver reads
  task automatic t_lab();
    i_ahc_host_model.wr(16'h0002);
    tick();
    chk("lab tx", tll, 1'b1);
    chk("lab rx1", r1l, 1'b1);
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      if (i < 16) pl1_n <= 1'b0;
      else en1_n <= 1'b0;
      @(posedge clk);
      pl1_n <= 1'b1;
      en1_n <= 1'b1;
      #1;
      if (i == 15) chk("lab tx end", tll, 1'b0);
    end
    tick();
    chk("lab rx1 end", r1l, 1'b0);
    chk("lab rx2", r2l, 1'b1);
    i_ahc_host_model.wr(16'h0000);
    $display("test label done");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    {rst, mr_n, pl1_n, pl2_n, en1_n, en2_n, h1, h2} = 8'hff;
    {lv, rxw, txw, w1, w2} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_ctrl();
    t_stat();
    t_par();
    t_fmt();
    t_dec();
    t_lab();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule

// ---- design/ahc_pkg.sv ----
/*
  Package for the host configuration and status register block.
  Assumes a single 1 MHz-class system clock domain.
*/
package ahc_pkg;
  // ==========================================================
  // Control word field positions
  localparam int unsigned CW_RX1_RATE = 0;
  localparam int unsigned CW_LABEL_MEM = 1;
  localparam int unsigned CW_RX1_LABEL_EN = 2;
  localparam int unsigned CW_RX2_LABEL_EN = 3;
  localparam int unsigned CW_TX_PAR_EN = 4;
  localparam int unsigned CW_LOOPBACK_N = 5;
  localparam int unsigned CW_RX1_DEC_EN = 6;
  localparam int unsigned CW_RX1_B9 = 7;
  localparam int unsigned CW_RX1_B10 = 8;
  localparam int unsigned CW_RX2_DEC_EN = 9;
  localparam int unsigned CW_RX2_B9 = 10;
  localparam int unsigned CW_RX2_B10 = 11;
  localparam int unsigned CW_TX_PAR_POL = 12;
  localparam int unsigned CW_TX_RATE = 13;
  localparam int unsigned CW_RX2_RATE = 14;
  localparam int unsigned CW_FORMAT = 15;
  localparam logic [15:0] CW_RESET = 16'h0000;
  // ==========================================================
  // Rate dividers and FIFO thresholds
  localparam logic [6:0] DIV_FAST = 7'h0a;
  localparam logic [6:0] DIV_SLOW = 7'h50;
  localparam logic [5:0] FIFO_HALF = 6'h10;
  localparam logic [5:0] FIFO_DEPTH = 6'h20;
  localparam logic [4:0] LABEL_COUNT = 5'h10;

  // FIFO occupancy for the three queues
  typedef struct packed {
    logic [5:0] rx1;
    logic [5:0] rx2;
    logic [5:0] tx;
  } ahc_levels_t;

  // Whole state of the register block
  typedef struct packed {
    logic [15:0] control_word;
    logic [15:0] bus_data;
    logic cw_strobe_d;
    logic label_mem_d;
    logic [4:0] tx_label_left;
    logic [4:0] rx1_label_left;
    logic [4:0] rx2_label_left;
    logic rx1_en_d;
    logic rx2_en_d;
    logic pl_d;
  } ahc_state_t;
endpackage

// ---- design/ahc_regs.sv ----
/*
  Control word and status register of a dual-receiver, single-transmitter
  serial interface, reached by strobes on a 16-bit host bus.
  Assumes FIFO levels and strobes are synchronous to ref_clk_i.
*/
// Notes on behaviour
// - Control-write strobe low captures all 16 host bus bits into control word.
// - Read strobe low with chooser 1 drives control word onto host bus.
// - Each channel rate bit: 0 means clock/10, 1 means clock/80.
// - Label access bit 1 steers next 16 loads and reads to label memory.
// - Parity enable 0 sends bit 32 as data, 1 substitutes parity.
// - Self-test bit 0 loops transmitter outputs into receivers; 1 normal.
// - Receiver 1 decoder checks bits 9,10 against control bits 7,8.
// - Receiver 2 decoder checks bits 9,10 against control bits 10,11.
// - Parity polarity 0 odd, 1 even.
// - Format 0 maps scrambled bit layout onto two half-words.
// - Format 1 maps bits 16..9 plus label, then parity and 31..17.
// - Read strobe with chooser 0 drives 9-bit status, upper bits zero.
// - Data-ready bit set while receiver FIFO holds data; pin inverted.
// - Half-full bit set at 16 words or more; pin inverted.
// - Full bit set when receiver FIFO full; pin inverted.
// - Transmit-empty bit set when transmitter FIFO holds nothing.
// - Transmit-full bit set when transmitter FIFO full; pin inverted.
// - Transmit half-full bit set at 16 words or more; pin inverted.
// - Chooser 0 selects first half-word, 1 second, on receiver reads.
// - Label recognition bit 1 discards words whose label is unmatched.
`timescale 1ns/1ps
module ahc_regs (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic master_reset_n_i,
  input wire logic control_write_strobe_n_i,
  input wire logic register_read_strobe_n_i,
  input wire logic byte_choose_i,
  input wire logic [15:0] host_bus_i,
  output logic [15:0] host_bus_o,
  output logic host_bus_oe_o,
  input wire ahc_pkg::ahc_levels_t levels_i,
  input wire logic tx_load_low_half_n_i,
  input wire logic tx_load_high_half_n_i,
  input wire logic rx1_read_n_i,
  input wire logic rx2_read_n_i,
  input wire logic [31:0] rx_word_i,
  input wire logic [7:0] rx_label_i,
  output logic [15:0] rx_half_o,
  input wire logic [31:0] tx_word_i,
  output logic tx_bit32_o,
  input wire logic [31:0] rx1_word_i,
  input wire logic rx1_label_hit_i,
  output logic rx1_accept_o,
  input wire logic [31:0] rx2_word_i,
  input wire logic rx2_label_hit_i,
  output logic rx2_accept_o,
  output logic [6:0] rx1_divide_o,
  output logic [6:0] rx2_divide_o,
  output logic [6:0] tx_divide_o,
  output logic loopback_o,
  output logic tx_label_load_o,
  output logic rx1_label_read_o,
  output logic rx2_label_read_o,
  output logic [8:0] fifo_status_o,
  output logic rx1_has_data_n_o,
  output logic rx1_half_level_n_o,
  output logic rx1_queue_full_n_o,
  output logic rx2_has_data_n_o,
  output logic rx2_half_level_n_o,
  output logic rx2_queue_full_n_o,
  output logic tx_queue_full_n_o,
  output logic tx_half_level_n_o
);
  // ========================================================
  // State
  ahc_pkg::ahc_state_t state_reg, state_next;
  logic [15:0] cw;
  logic [8:0] status;
  logic cw_write, pl_fall, rx1_fall, rx2_fall, rise_mem;
  logic [15:0] half_a, half_b;
  logic tx_par;
  logic in_reset;

  assign in_reset = reset_i | ~master_reset_n_i;
  assign cw = state_reg.control_word;

  // ========================================================
  // Status and pins
  always_comb begin
    status[0] = levels_i.rx1 != 6'h00;
    status[1] = levels_i.rx1 >= ahc_pkg::FIFO_HALF;
    status[2] = levels_i.rx1 == ahc_pkg::FIFO_DEPTH;
    status[3] = levels_i.rx2 != 6'h00;
    status[4] = levels_i.rx2 >= ahc_pkg::FIFO_HALF;
    status[5] = levels_i.rx2 == ahc_pkg::FIFO_DEPTH;
    status[6] = levels_i.tx == 6'h00;
    status[7] = levels_i.tx == ahc_pkg::FIFO_DEPTH;
    status[8] = levels_i.tx >= ahc_pkg::FIFO_HALF;
  end
  assign fifo_status_o = status;
  assign rx1_has_data_n_o = ~status[0];
  assign rx1_half_level_n_o = ~status[1];
  assign rx1_queue_full_n_o = ~status[2];
  assign rx2_has_data_n_o = ~status[3];
  assign rx2_half_level_n_o = ~status[4];
  assign rx2_queue_full_n_o = ~status[5];
  assign tx_queue_full_n_o = ~status[7];
  assign tx_half_level_n_o = ~status[8];

  // ========================================================
  // Configuration decode
  assign rx1_divide_o = cw[ahc_pkg::CW_RX1_RATE] ? ahc_pkg::DIV_SLOW : ahc_pkg::DIV_FAST;
  assign rx2_divide_o = cw[ahc_pkg::CW_RX2_RATE] ? ahc_pkg::DIV_SLOW : ahc_pkg::DIV_FAST;
  assign tx_divide_o = cw[ahc_pkg::CW_TX_RATE] ? ahc_pkg::DIV_SLOW : ahc_pkg::DIV_FAST;
  assign loopback_o = ~cw[ahc_pkg::CW_LOOPBACK_N];

  // Transmit 32nd bit: data, or odd/even parity over bits 1..31
  assign tx_par = ~(^tx_word_i[30:0]) ^ cw[ahc_pkg::CW_TX_PAR_POL];
  assign tx_bit32_o = cw[ahc_pkg::CW_TX_PAR_EN] ? tx_par : tx_word_i[31];

  // Receive acceptance: label match and bit 9/10 decoder
  assign rx1_accept_o = (~cw[ahc_pkg::CW_RX1_LABEL_EN] | rx1_label_hit_i)
    & (~cw[ahc_pkg::CW_RX1_DEC_EN]
       | (rx1_word_i[8] == cw[ahc_pkg::CW_RX1_B9] && rx1_word_i[9] == cw[ahc_pkg::CW_RX1_B10]));
  assign rx2_accept_o = (~cw[ahc_pkg::CW_RX2_LABEL_EN] | rx2_label_hit_i)
    & (~cw[ahc_pkg::CW_RX2_DEC_EN]
       | (rx2_word_i[8] == cw[ahc_pkg::CW_RX2_B9] && rx2_word_i[9] == cw[ahc_pkg::CW_RX2_B10]));

  // ========================================================
  // Word to half-word mapping, ARINC bit n is index n-1
  always_comb begin
    if (cw[ahc_pkg::CW_FORMAT]) begin
      half_a = {rx_word_i[15:8], rx_word_i[7:0]};
      half_b = {rx_word_i[31], rx_word_i[30:16]};
    end else begin
      half_a = {rx_word_i[12:8], rx_word_i[30:29], rx_word_i[31], rx_word_i[7:0]};
      half_b = rx_word_i[28:13];
    end
  end

  // Edges of strobes and label access mode
  assign cw_write = state_reg.cw_strobe_d & ~control_write_strobe_n_i;
  assign pl_fall = state_reg.pl_d & ~(tx_load_low_half_n_i & tx_load_high_half_n_i);
  assign rx1_fall = state_reg.rx1_en_d & ~rx1_read_n_i;
  assign rx2_fall = state_reg.rx2_en_d & ~rx2_read_n_i;
  assign rise_mem = cw[ahc_pkg::CW_LABEL_MEM] & ~state_reg.label_mem_d;
  assign tx_label_load_o = cw[ahc_pkg::CW_LABEL_MEM] && state_reg.tx_label_left != 5'h00;
  assign rx1_label_read_o = cw[ahc_pkg::CW_LABEL_MEM] && state_reg.rx1_label_left != 5'h00;
  assign rx2_label_read_o = cw[ahc_pkg::CW_LABEL_MEM] && state_reg.rx2_label_left != 5'h00;
  assign rx_half_o = byte_choose_i ? half_b : half_a;

  // ========================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.cw_strobe_d = control_write_strobe_n_i;
    state_next.pl_d = tx_load_low_half_n_i & tx_load_high_half_n_i;
    state_next.rx1_en_d = rx1_read_n_i;
    state_next.rx2_en_d = rx2_read_n_i;
    state_next.label_mem_d = cw[ahc_pkg::CW_LABEL_MEM];
    if (cw_write) begin
      state_next.control_word = host_bus_i;
    end
    if (rise_mem) begin
      state_next.tx_label_left = ahc_pkg::LABEL_COUNT;
      state_next.rx1_label_left = ahc_pkg::LABEL_COUNT;
      state_next.rx2_label_left = ahc_pkg::LABEL_COUNT;
    end else begin
      if (pl_fall && tx_label_load_o) begin
        state_next.tx_label_left = state_reg.tx_label_left - 5'h01;
      end
      if (rx1_fall && rx1_label_read_o) begin
        state_next.rx1_label_left = state_reg.rx1_label_left - 5'h01;
      end
      if (rx2_fall && rx2_label_read_o) begin
        state_next.rx2_label_left = state_reg.rx2_label_left - 5'h01;
      end
    end
    // Read data registered each cycle from the chooser, strobe or not
    if (byte_choose_i) begin
      state_next.bus_data = cw;
    end else begin
      state_next.bus_data = {7'h00, status};
    end
  end

  // State register, either reset clears state but sets the strobe delays high
  always_ff @(posedge ref_clk_i or posedge in_reset) begin
    if (in_reset) begin
      state_reg <= '0;
      state_reg.control_word <= ahc_pkg::CW_RESET;
      state_reg.cw_strobe_d <= 1'b1;
      state_reg.pl_d <= 1'b1;
      state_reg.rx1_en_d <= 1'b1;
      state_reg.rx2_en_d <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bus drive while read strobe low
  assign host_bus_oe_o = ~register_read_strobe_n_i;
  assign host_bus_o = register_read_strobe_n_i ? 16'h0000 : state_reg.bus_data;

  // ========================================================
  // Checks
  a_cw_capture: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    cw_write |=> cw == $past(host_bus_i)) else $error("control word not captured");
  a_cw_read: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    (byte_choose_i && !register_read_strobe_n_i && $stable(cw) && $past(byte_choose_i))
      |-> host_bus_o == cw) else $error("control word read wrong");
  a_status_read: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    (!byte_choose_i && !register_read_strobe_n_i && $past(!byte_choose_i))
      |-> host_bus_o == {7'h00, $past(fifo_status_o)}) else $error("status read wrong");
  a_rate_div: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    tx_divide_o == (cw[13] ? 7'h50 : 7'h0a)) else $error("transmit divide wrong");
  a_parity_odd: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    (cw[4] && !cw[12]) |-> ^{tx_bit32_o, tx_word_i[30:0]}) else $error("odd parity wrong");
  a_data_bit32: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    !cw[4] |-> tx_bit32_o == tx_word_i[31]) else $error("bit 32 not data");
  a_loop_test: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    loopback_o != cw[5]) else $error("loopback wrong");
  a_rx1_decode: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    (cw[6] && rx1_word_i[8] != cw[7]) |-> !rx1_accept_o) else $error("rx1 decoder passed");
  a_rx2_decode: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    (cw[9] && rx2_word_i[9] != cw[11]) |-> !rx2_accept_o) else $error("rx2 decoder passed");
  a_half_pins: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    (levels_i.rx1 == 6'h10) |-> !rx1_half_level_n_o && !rx1_has_data_n_o) else $error("half pin wrong");
  a_tx_empty: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    fifo_status_o[6] == (levels_i.tx == 6'h00)) else $error("tx empty wrong");
  a_label_count: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    rise_mem |=> state_reg.tx_label_left == 5'h10) else $error("label count not loaded");

  // Label access counters step once per falling strobe
  a_tx_label_step: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    (pl_fall && tx_label_load_o && !rise_mem)
      |=> state_reg.tx_label_left == $past(state_reg.tx_label_left) - 5'h01)
    else $error("transmit label count did not step");
  a_rx1_label_step: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    (rx1_fall && rx1_label_read_o && !rise_mem)
      |=> state_reg.rx1_label_left == $past(state_reg.rx1_label_left) - 5'h01)
    else $error("receiver 1 label count did not step");

  // Receiver status bits follow the levels, pins inverted
  a_rx1_ready: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    fifo_status_o[0] == (levels_i.rx1 != 6'h00) && rx1_has_data_n_o == !fifo_status_o[0])
    else $error("rx1 data ready wrong");
  a_rx2_ready: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    fifo_status_o[3] == (levels_i.rx2 != 6'h00) && rx2_has_data_n_o == !fifo_status_o[3])
    else $error("rx2 data ready wrong");
  a_rx2_half: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    fifo_status_o[4] == (levels_i.rx2 >= ahc_pkg::FIFO_HALF) && rx2_half_level_n_o == !fifo_status_o[4])
    else $error("rx2 half level wrong");
  a_rx1_full: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    fifo_status_o[2] == (levels_i.rx1 == ahc_pkg::FIFO_DEPTH) && rx1_queue_full_n_o == !fifo_status_o[2])
    else $error("rx1 full wrong");
  a_rx2_full: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    fifo_status_o[5] == (levels_i.rx2 == ahc_pkg::FIFO_DEPTH) && rx2_queue_full_n_o == !fifo_status_o[5])
    else $error("rx2 full wrong");

  // Transmit queue status bits and pins
  a_tx_full: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    fifo_status_o[7] == (levels_i.tx == ahc_pkg::FIFO_DEPTH) && tx_queue_full_n_o == !fifo_status_o[7])
    else $error("tx full wrong");
  a_tx_half: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    fifo_status_o[8] == (levels_i.tx >= ahc_pkg::FIFO_HALF) && tx_half_level_n_o == !fifo_status_o[8])
    else $error("tx half level wrong");

  // Even parity gives an even count of ones over all 32 bits
  a_parity_even: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    (cw[ahc_pkg::CW_TX_PAR_EN] && cw[ahc_pkg::CW_TX_PAR_POL]) |-> !(^{tx_bit32_o, tx_word_i[30:0]}))
    else $error("even parity wrong");

  // Decoder and label filter reject the other cases
  a_rx1_bit10: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    (cw[ahc_pkg::CW_RX1_DEC_EN] && rx1_word_i[9] != cw[ahc_pkg::CW_RX1_B10]) |-> !rx1_accept_o)
    else $error("rx1 bit 10 decoder passed");
  a_rx2_bit9: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    (cw[ahc_pkg::CW_RX2_DEC_EN] && rx2_word_i[8] != cw[ahc_pkg::CW_RX2_B9]) |-> !rx2_accept_o)
    else $error("rx2 bit 9 decoder passed");
  a_rx1_label: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    (cw[ahc_pkg::CW_RX1_LABEL_EN] && !rx1_label_hit_i) |-> !rx1_accept_o)
    else $error("rx1 unmatched label passed");
  a_rx2_label: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    (cw[ahc_pkg::CW_RX2_LABEL_EN] && !rx2_label_hit_i) |-> !rx2_accept_o)
    else $error("rx2 unmatched label passed");

  // Half-word mapping in both formats
  a_unscrambled: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    (cw[ahc_pkg::CW_FORMAT] && !byte_choose_i) |-> rx_half_o == rx_word_i[15:0])
    else $error("unscrambled first half wrong");
  a_scrambled: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    (!cw[ahc_pkg::CW_FORMAT] && byte_choose_i) |-> rx_half_o == rx_word_i[28:13])
    else $error("scrambled second half wrong");

  // Bus released and zero outside a read
  a_bus_idle: assert property (@(posedge ref_clk_i) disable iff (in_reset)
    register_read_strobe_n_i |-> host_bus_o == 16'h0000 && !host_bus_oe_o)
    else $error("bus driven outside read");

  // Control word and label counters clear on reset
  a_reset_clear: assert property (@(posedge ref_clk_i)
    $past(in_reset) && !in_reset |-> cw == ahc_pkg::CW_RESET && state_reg.tx_label_left == 5'h00)
    else $error("reset did not clear state");

  // ========================================================
  // Coverage of main scenarios
  c_cw_write: cover property (@(posedge ref_clk_i) cw_write);
  c_label_mode: cover property (@(posedge ref_clk_i) rise_mem);
  c_rx1_full: cover property (@(posedge ref_clk_i) status[2]);
  c_status_read: cover property (@(posedge ref_clk_i) !register_read_strobe_n_i && !byte_choose_i);
  c_parity_on: cover property (@(posedge ref_clk_i) cw[ahc_pkg::CW_TX_PAR_EN] && tx_bit32_o);
endmodule
